// *** shared/bse_map.svh ***
// bse_map.svh: offsets, field positions, reset values and cycle counts
// of the branch/skip execution block.
// assumes: included by bare name; byte addresses on an 8-bit APB address.
`ifndef BSE_MAP_SVH
`define BSE_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BSE_OFF_INSTR      8'h00
`define BSE_OFF_OPND       8'h04
`define BSE_OFF_PC         8'h08
`define BSE_OFF_FLAGS      8'h0C
`define BSE_OFF_ZPTR       8'h10
`define BSE_OFF_NEXT       8'h14
`define BSE_OFF_STATE      8'h18
`define BSE_IO_BASE_HI     3'h1
`define BSE_IO_COUNT       8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BSE_INSTR_OP_LSB   0
`define BSE_INSTR_BIT_LSB  8
`define BSE_INSTR_IO_LSB   12
`define BSE_OPND_RD_LSB    0
`define BSE_OPND_RR_LSB    8
`define BSE_OPND_K_LSB     16
`define BSE_ST_BUSY        0
`define BSE_ST_CYC_LSB     4
`define BSE_ST_RES_LSB     8
`define BSE_ST_SP_LSB      16

// status flag bit positions
`define BSE_FLAG_C         0
`define BSE_FLAG_Z         1
`define BSE_FLAG_N         2
`define BSE_FLAG_V         3
`define BSE_FLAG_S         4
`define BSE_FLAG_H         5
`define BSE_FLAG_T         6
`define BSE_FLAG_I         7

// ----------------------------------------------------------------
// reset values, sizes and cycle counts
// ----------------------------------------------------------------
`define BSE_PC_RST         16'h0000
`define BSE_FLAGS_RST      8'h00
`define BSE_ZPTR_RST       16'h0000
`define BSE_STACK_DEPTH    16
`define BSE_CYC_ONE        3'h1
`define BSE_CYC_JUMP       3'h2
`define BSE_CYC_CALL       3'h3
`define BSE_CYC_RET        3'h4
`define BSE_CYC_IOBIT      3'h2
`define BSE_CYC_BR_TAKEN   3'h2
`define BSE_CYC_SKIP1      3'h2
`define BSE_CYC_SKIP2      3'h3

`endif

// *** shared/bse_pkg.sv ***
// bse_pkg: operation and state types of the branch/skip execution block.
// assumes: nothing beyond a SystemVerilog compiler.
package bse_pkg;

	// operation codes carried in the low bits of the instruction word
	typedef enum logic [4:0] {
		op_nop,
		op_pointer_jump,
		op_pointer_call,
		op_offset_jump,
		op_offset_call,
		op_ret,
		op_reti,
		op_compare_skip_equal,
		op_compare_regs,
		op_compare_regs_carry,
		op_compare_immediate,
		op_skip_reg_bit_clear,
		op_skip_reg_bit_one,
		op_skip_io_bit_clear,
		op_skip_io_bit_one,
		op_branch_flag_one,
		op_branch_flag_zero,
		op_branch_signed_ge,
		op_branch_signed_lt,
		op_io_bit_set_op,
		op_io_bit_clear_op,
		op_reg_clear,
		op_reg_set
	} bse_op_t;

	// sequencer states
	typedef enum logic [1:0] {
		st_idle,
		st_pop,
		st_busy
	} bse_state_t;

endpackage

// *** verilog/bse_stack_mem.sv ***
// bse_stack_mem: return-address stack storage, one write and one read port.
// assumes: single clock; read data appear one edge after rd_en.
`timescale 1ns/1ps
`default_nettype none
`include "bse_map.svh"

module bse_stack_mem (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        rd_en,
	input  wire logic [3:0]  rd_addr,
	output var  logic [15:0] rd_data
);

	logic [15:0] mem_reg [0:`BSE_STACK_DEPTH-1];

	// storage write, no reset on the array
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= 16'h0000;
		end else if (rd_en) begin
			rd_data <= mem_reg[rd_addr];
		end
	end

endmodule // bse_stack_mem
`default_nettype wire

// *** verilog/bse_exec.sv ***
// bse_exec: executes control-flow, compare and skip operations on an
// 8-bit core model whose state is reached over APB.
// assumes: APB master on clk (40 MHz), asynchronous active-low resetn.
`timescale 1ns/1ps
`default_nettype none
`include "bse_map.svh"

module bse_exec (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        exec_busy
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [15:0]          pc_reg;
	logic [7:0]           flags_reg;
	logic [15:0]          z_reg;
	logic [31:0]          opnd_reg;
	logic                 next2_reg;
	logic [3:0]           sp_reg;
	logic [2:0]           cnt_reg;
	logic [2:0]           last_cyc_reg;
	logic [7:0]           res_reg;
	logic                 reti_reg;
	bse_pkg::bse_state_t  state_reg;
	logic [7:0]           io_bank [0:`BSE_IO_COUNT-1];
	logic [15:0]          stk_rdata;

	logic                 setup;
	logic                 wr_acc;
	logic                 go;
	logic                 io_hit;
	logic                 any_hit;
	logic [31:0]          rd_mux;
	bse_pkg::bse_op_t     op;
	logic [2:0]           bsel;
	logic [2:0]           iosel;
	logic [7:0]           rd_val;
	logic [7:0]           rr_val;
	logic [11:0]          k_val;
	logic [7:0]           io_cur;
	logic [15:0]          pc_rel;
	logic [7:0]           diff;
	logic                 cin;
	logic                 skip;
	logic                 taken;
	logic [15:0]          d_pc;
	logic [2:0]           d_cyc;
	logic [7:0]           d_flags;
	logic                 d_push;
	logic                 d_pop;
	logic                 d_io_wr;
	logic [7:0]           d_io_val;
	logic                 d_res_wr;
	logic [7:0]           d_res;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// address match against one word offset
	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] off);
		return a == off;
	endfunction

	// one bit of a byte compared with the wanted level
	function automatic logic bit_test(input logic [7:0] v,
		input logic [2:0] s, input logic want);
		return v[s] == want;
	endfunction

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// setup phase seen, access phase completes with registered pready
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite;
	assign io_hit = (paddr[7:5] == `BSE_IO_BASE_HI) & (paddr[1:0] == 2'h0);
	assign any_hit = io_hit | reg_hit(paddr, `BSE_OFF_INSTR)
		| reg_hit(paddr, `BSE_OFF_OPND) | reg_hit(paddr, `BSE_OFF_PC)
		| reg_hit(paddr, `BSE_OFF_FLAGS) | reg_hit(paddr, `BSE_OFF_ZPTR)
		| reg_hit(paddr, `BSE_OFF_NEXT) | reg_hit(paddr, `BSE_OFF_STATE);
	// an instruction write starts execution unless one is running
	assign go = wr_acc & reg_hit(paddr, `BSE_OFF_INSTR) & ~exec_busy;

	// read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (io_hit) begin
			rd_mux[7:0] = io_bank[paddr[4:2]];
		end else if (reg_hit(paddr, `BSE_OFF_OPND)) begin
			rd_mux = opnd_reg;
		end else if (reg_hit(paddr, `BSE_OFF_PC)) begin
			rd_mux[15:0] = pc_reg;
		end else if (reg_hit(paddr, `BSE_OFF_FLAGS)) begin
			rd_mux[7:0] = flags_reg;
		end else if (reg_hit(paddr, `BSE_OFF_ZPTR)) begin
			rd_mux[15:0] = z_reg;
		end else if (reg_hit(paddr, `BSE_OFF_NEXT)) begin
			rd_mux[0] = next2_reg;
		end else if (reg_hit(paddr, `BSE_OFF_STATE)) begin
			rd_mux[`BSE_ST_BUSY] = exec_busy;
			rd_mux[`BSE_ST_CYC_LSB+:3] = last_cyc_reg;
			rd_mux[`BSE_ST_RES_LSB+:8] = res_reg;
			rd_mux[`BSE_ST_SP_LSB+:4] = sp_reg;
		end
	end

	// answer registered in setup, presented for one access cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~any_hit;
			if (setup) begin
				prdata <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// operand fields
	// ----------------------------------------------------------------
	assign op     = bse_pkg::bse_op_t'(pwdata[`BSE_INSTR_OP_LSB+:5]);
	assign bsel   = pwdata[`BSE_INSTR_BIT_LSB+:3];
	assign iosel  = pwdata[`BSE_INSTR_IO_LSB+:3];
	assign rd_val = opnd_reg[`BSE_OPND_RD_LSB+:8];
	assign rr_val = opnd_reg[`BSE_OPND_RR_LSB+:8];
	assign k_val  = opnd_reg[`BSE_OPND_K_LSB+:12];
	assign io_cur = io_bank[iosel];
	// relative target pc + k + 1 with k sign-extended
	assign pc_rel = pc_reg + {{4{k_val[11]}}, k_val} + 16'h0001;
	assign cin    = (op == bse_pkg::op_compare_regs_carry)
		& flags_reg[`BSE_FLAG_C];
	assign diff   = rd_val - rr_val - {7'h00, cin};

	// ----------------------------------------------------------------
	// decode: next pc, cycle count and side effects of one operation
	// ----------------------------------------------------------------
	always_comb begin
		d_pc     = pc_reg + 16'h0001;
		d_cyc    = `BSE_CYC_ONE;
		d_flags  = flags_reg;
		d_push   = 1'b0;
		d_pop    = 1'b0;
		d_io_wr  = 1'b0;
		d_io_val = io_cur;
		d_res_wr = 1'b0;
		d_res    = 8'h00;
		skip     = 1'b0;
		taken    = 1'b0;
		unique case (op)
			bse_pkg::op_pointer_jump: begin
				d_pc  = z_reg;
				d_cyc = `BSE_CYC_JUMP;
			end
			bse_pkg::op_pointer_call: begin
				d_pc   = z_reg;
				d_cyc  = `BSE_CYC_CALL;
				d_push = 1'b1;
			end
			bse_pkg::op_offset_jump: begin
				d_pc  = pc_rel;
				d_cyc = `BSE_CYC_JUMP;
			end
			bse_pkg::op_offset_call: begin
				d_pc   = pc_rel;
				d_cyc  = `BSE_CYC_CALL;
				d_push = 1'b1;
			end
			bse_pkg::op_ret, bse_pkg::op_reti: begin
				d_cyc = `BSE_CYC_RET;
				d_pop = 1'b1;
			end
			bse_pkg::op_compare_skip_equal: begin
				skip = (rd_val == rr_val);
			end
			bse_pkg::op_compare_regs, bse_pkg::op_compare_regs_carry,
			bse_pkg::op_compare_immediate: begin
				// carry form keeps Z only while the result stays zero
				d_flags[`BSE_FLAG_Z] = (diff == 8'h00)
					& (~cin_form(op) | flags_reg[`BSE_FLAG_Z]);
				d_flags[`BSE_FLAG_N] = diff[7];
				d_flags[`BSE_FLAG_V] = (rd_val[7] & ~rr_val[7] & ~diff[7])
					| (~rd_val[7] & rr_val[7] & diff[7]);
				d_flags[`BSE_FLAG_C] = (~rd_val[7] & rr_val[7])
					| (rr_val[7] & diff[7]) | (diff[7] & ~rd_val[7]);
				d_flags[`BSE_FLAG_H] = (~rd_val[3] & rr_val[3])
					| (rr_val[3] & diff[3]) | (diff[3] & ~rd_val[3]);
			end
			bse_pkg::op_skip_reg_bit_clear: begin
				skip = bit_test(rd_val, bsel, 1'b0);
			end
			bse_pkg::op_skip_reg_bit_one: begin
				skip = bit_test(rd_val, bsel, 1'b1);
			end
			bse_pkg::op_skip_io_bit_clear: begin
				skip = bit_test(io_cur, bsel, 1'b0);
			end
			bse_pkg::op_skip_io_bit_one: begin
				skip = bit_test(io_cur, bsel, 1'b1);
			end
			// bit select picks C, Z, N, V, S, H, T or I
			bse_pkg::op_branch_flag_one: begin
				taken = bit_test(flags_reg, bsel, 1'b1);
			end
			bse_pkg::op_branch_flag_zero: begin
				taken = bit_test(flags_reg, bsel, 1'b0);
			end
			bse_pkg::op_branch_signed_ge: begin
				taken = ~(flags_reg[`BSE_FLAG_N]
					^ flags_reg[`BSE_FLAG_V]);
			end
			bse_pkg::op_branch_signed_lt: begin
				taken = flags_reg[`BSE_FLAG_N]
					^ flags_reg[`BSE_FLAG_V];
			end
			bse_pkg::op_io_bit_set_op: begin
				d_io_wr  = 1'b1;
				d_io_val = io_cur | (8'h01 << bsel);
				d_cyc    = `BSE_CYC_IOBIT;
			end
			bse_pkg::op_io_bit_clear_op: begin
				d_io_wr  = 1'b1;
				d_io_val = io_cur & ~(8'h01 << bsel);
				d_cyc    = `BSE_CYC_IOBIT;
			end
			bse_pkg::op_reg_clear: begin
				d_res_wr = 1'b1;
				d_flags[`BSE_FLAG_Z] = 1'b1;
				d_flags[`BSE_FLAG_N] = 1'b0;
				d_flags[`BSE_FLAG_V] = 1'b0;
			end
			bse_pkg::op_reg_set: begin
				d_res_wr = 1'b1;
				d_res    = 8'hFF;
			end
			bse_pkg::op_nop: begin
				d_cyc = `BSE_CYC_ONE;
			end
			default: begin
				d_cyc = `BSE_CYC_ONE;
			end
		endcase
		// skip distance depends on the length of the next instruction
		if (skip) begin
			d_pc  = pc_reg + (next2_reg ? 16'h0003 : 16'h0002);
			d_cyc = next2_reg ? `BSE_CYC_SKIP2 : `BSE_CYC_SKIP1;
		end
		if (taken) begin
			d_pc  = pc_rel;
			d_cyc = `BSE_CYC_BR_TAKEN;
		end
	end

	// carry-compare form test, used by the zero flag chain
	function automatic logic cin_form(input bse_pkg::bse_op_t o);
		return o == bse_pkg::op_compare_regs_carry;
	endfunction

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// state steps through pop and the remaining busy cycles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= bse_pkg::st_idle;
		end else begin
			unique case (state_reg)
				bse_pkg::st_idle: begin
					if (go) begin
						state_reg <= d_pop ? bse_pkg::st_pop
							: bse_pkg::st_busy;
					end
				end
				bse_pkg::st_pop: begin
					state_reg <= bse_pkg::st_busy;
				end
				bse_pkg::st_busy: begin
					if (cnt_reg == 3'h1) begin
						state_reg <= bse_pkg::st_idle;
					end
				end
			endcase
		end
	end

	// busy lasts exactly the operation's cycle count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg      <= 3'h0;
			exec_busy    <= 1'b0;
			last_cyc_reg <= 3'h0;
		end else if (go) begin
			cnt_reg      <= d_cyc;
			exec_busy    <= 1'b1;
			last_cyc_reg <= d_cyc;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg   <= cnt_reg - 3'h1;
			exec_busy <= (cnt_reg != 3'h1);
		end
	end

	// program counter: operation, stack pop, or software while idle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_reg <= `BSE_PC_RST;
		end else if (go && !d_pop) begin
			pc_reg <= d_pc;
		end else if (state_reg == bse_pkg::st_pop) begin
			pc_reg <= stk_rdata;
		end else if (wr_acc && !exec_busy
			&& reg_hit(paddr, `BSE_OFF_PC)) begin
			pc_reg <= pwdata[15:0];
		end
	end

	// status flags; interrupt return sets the global enable
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_reg <= `BSE_FLAGS_RST;
			reti_reg  <= 1'b0;
		end else if (go) begin
			flags_reg <= d_flags;
			reti_reg  <= (op == bse_pkg::op_reti);
		end else if (state_reg == bse_pkg::st_pop && reti_reg) begin
			flags_reg[`BSE_FLAG_I] <= 1'b1;
		end else if (wr_acc && !exec_busy
			&& reg_hit(paddr, `BSE_OFF_FLAGS)) begin
			flags_reg <= pwdata[7:0];
		end
	end

	// stack pointer: push at call issue, pop at return issue
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sp_reg <= 4'h0;
		end else if (go && d_push) begin
			sp_reg <= sp_reg + 4'h1;
		end else if (go && d_pop) begin
			sp_reg <= sp_reg - 4'h1;
		end
	end

	// software-written operand, pointer and next-length registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			opnd_reg  <= 32'h0000_0000;
			z_reg     <= `BSE_ZPTR_RST;
			next2_reg <= 1'b0;
		end else if (wr_acc && !exec_busy) begin
			if (reg_hit(paddr, `BSE_OFF_OPND)) begin
				opnd_reg <= pwdata;
			end
			if (reg_hit(paddr, `BSE_OFF_ZPTR)) begin
				z_reg <= pwdata[15:0];
			end
			if (reg_hit(paddr, `BSE_OFF_NEXT)) begin
				next2_reg <= pwdata[0];
			end
		end
	end

	// register result of clear/set; compares never write it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			res_reg <= 8'h00;
		end else if (go && d_res_wr) begin
			res_reg <= d_res;
		end
	end

	// io registers: single-bit ops or software writes
	generate
		for (genvar i = 0; i < `BSE_IO_COUNT; i++) begin : g_io
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					io_bank[i] <= 8'h00;
				end else if (go && d_io_wr && iosel == 3'(i)) begin
					io_bank[i] <= d_io_val;
				end else if (wr_acc && io_hit && paddr[4:2] == 3'(i)) begin
					io_bank[i] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// return-address stack
	bse_stack_mem u_stack (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (go & d_push),
		.wr_addr (sp_reg),
		.wr_data (pc_reg + 16'h0001),
		.rd_en   (go & d_pop),
		.rd_addr (sp_reg - 4'h1),
		.rd_data (stk_rdata)
	);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_busy1; exec_busy ##1 !exec_busy; endsequence
	sequence s_busy2; exec_busy[*2] ##1 !exec_busy; endsequence
	sequence s_busy3; exec_busy[*3] ##1 !exec_busy; endsequence
	sequence s_busy4; exec_busy[*4] ##1 !exec_busy; endsequence

	chk_ptr_jump: assert property (go && op == bse_pkg::op_pointer_jump
		|=> pc_reg == $past(z_reg) && flags_reg == $past(flags_reg)
		##0 s_busy2) else $error("pointer jump wrong");
	chk_ptr_call: assert property (go && op == bse_pkg::op_pointer_call
		|=> pc_reg == $past(z_reg) && sp_reg == $past(sp_reg) + 4'h1
		##0 s_busy3) else $error("pointer call wrong");
	chk_skip_equal: assert property (go && rd_val == rr_val && next2_reg
		&& op == bse_pkg::op_compare_skip_equal
		|=> pc_reg == $past(pc_reg) + 16'h0003 ##0 s_busy3)
		else $error("equal skip wrong");
	chk_cmp_equal: assert property (go && rd_val == rr_val
		&& (op == bse_pkg::op_compare_regs
		|| op == bse_pkg::op_compare_immediate)
		|=> flags_reg[1:0] == 2'h2 && res_reg == $past(res_reg)
		##0 s_busy1) else $error("compare flags wrong");
	chk_reg_bit_skip: assert property (go && !next2_reg && !rd_val[bsel]
		&& op == bse_pkg::op_skip_reg_bit_clear
		|=> pc_reg == $past(pc_reg) + 16'h0002 ##0 s_busy2)
		else $error("register bit skip wrong");
	chk_io_skip_one: assert property (go && !io_cur[bsel]
		&& op == bse_pkg::op_skip_io_bit_one
		|=> pc_reg == $past(pc_reg) + 16'h0001 ##0 s_busy1)
		else $error("io skip taken wrongly");
	chk_branch_taken: assert property (go && flags_reg[bsel]
		&& op == bse_pkg::op_branch_flag_one
		|=> pc_reg == $past(pc_rel) ##0 s_busy2)
		else $error("flag branch not taken");
	chk_branch_idle: assert property (go && flags_reg[bsel]
		&& op == bse_pkg::op_branch_flag_zero
		|=> pc_reg == $past(pc_reg) + 16'h0001 ##0 s_busy1)
		else $error("flag branch taken wrongly");
	chk_signed_lt: assert property (go && op == bse_pkg::op_branch_signed_lt
		&& (flags_reg[`BSE_FLAG_N] ^ flags_reg[`BSE_FLAG_V])
		|=> pc_reg == $past(pc_rel)) else $error("signed lt wrong");
	chk_io_set_bit: assert property (go && op == bse_pkg::op_io_bit_set_op
		|=> io_bank[$past(iosel)][$past(bsel)] ##0 s_busy2)
		else $error("io bit set wrong");
	chk_ret_timing: assert property (go && op == bse_pkg::op_reti
		|=> s_busy4 and (##1 flags_reg[`BSE_FLAG_I]))
		else $error("return timing wrong");

endmodule // bse_exec
`default_nettype wire

// *** dv/branch_skip_exec_control_bench.sv ***
// branch_skip_exec_control_bench: directed APB bench for bse_exec.
// assumes: bse_pkg compiled first, bse_map.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "bse_map.svh"

module branch_skip_exec_control_bench;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        exec_busy;
	logic [31:0] rd;
	logic        err;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	always #12.5 clk = ~clk;

	bse_exec u_dut (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .exec_busy(exec_busy));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready, then one idle edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	// start one operation and count the cycles that busy stands high
	task exec(input bse_pkg::bse_op_t op, input int b, input int io,
		input int n);
		int k;
		apb(1'b1, `BSE_OFF_INSTR,
			{17'h0, io[2:0], 1'b0, b[2:0], 3'h0, op});
		k = 0;
		while (exec_busy === 1'b1 && k < 8) begin
			k++;
			@(posedge clk);
		end
		check(k, n);
	endtask

	task t_jumps;
		apb(1'b1, `BSE_OFF_FLAGS, 32'h25);
		apb(1'b1, `BSE_OFF_ZPTR, 32'h1234);
		exec(bse_pkg::op_pointer_jump, 0, 0, 2);
		rdchk(`BSE_OFF_PC, 32'h1234);
		apb(1'b1, `BSE_OFF_PC, 32'h40);
		exec(bse_pkg::op_pointer_call, 0, 0, 3);
		rdchk(`BSE_OFF_PC, 32'h1234);
		rdchk(`BSE_OFF_FLAGS, 32'h25);
		exec(bse_pkg::op_ret, 0, 0, 4);
		rdchk(`BSE_OFF_PC, 32'h41);
		apb(1'b1, `BSE_OFF_OPND, 32'h00050000);
		exec(bse_pkg::op_offset_jump, 0, 0, 2);
		rdchk(`BSE_OFF_PC, 32'h47);
		exec(bse_pkg::op_offset_call, 0, 0, 3);
		rdchk(`BSE_OFF_PC, 32'h4D);
		exec(bse_pkg::op_reti, 0, 0, 4);
		rdchk(`BSE_OFF_PC, 32'h48);
		rdchk(`BSE_OFF_FLAGS, 32'hA5);
		$display("test jumps done");
	endtask

	// every status bit: branch-if-one taken when one, branch-if-zero not taken when one and taken when zero
	task t_branch;
		apb(1'b1, `BSE_OFF_OPND, 32'h0FFE0000);
		for (int b = 0; b < 8; b++) begin
			apb(1'b1, `BSE_OFF_FLAGS, 32'h1 << b);
			apb(1'b1, `BSE_OFF_PC, 32'h100);
			exec(bse_pkg::op_branch_flag_one, b, 0, 2);
			rdchk(`BSE_OFF_PC, 32'hFF);
			exec(bse_pkg::op_branch_flag_zero, b, 0, 1);
			apb(1'b1, `BSE_OFF_FLAGS, ~(32'h1 << b) & 32'hFF);
			exec(bse_pkg::op_branch_flag_zero, b, 0, 2);
			rdchk(`BSE_OFF_PC, 32'hFF);
		end
		apb(1'b1, `BSE_OFF_FLAGS, 32'h04);
		exec(bse_pkg::op_branch_signed_lt, 0, 0, 2);
		exec(bse_pkg::op_branch_signed_ge, 0, 0, 1);
		apb(1'b1, `BSE_OFF_FLAGS, 32'h0C);
		exec(bse_pkg::op_branch_signed_ge, 0, 0, 2);
		exec(bse_pkg::op_branch_signed_lt, 0, 0, 1);
		$display("test branch done");
	endtask

	task t_cmp;
		apb(1'b1, `BSE_OFF_FLAGS, 32'h0);
		apb(1'b1, `BSE_OFF_OPND, 32'h2010);
		exec(bse_pkg::op_compare_regs, 0, 0, 1);
		rdchk(`BSE_OFF_FLAGS, 32'h05);
		rdchk(`BSE_OFF_OPND, 32'h2010);
		apb(1'b1, `BSE_OFF_OPND, 32'h3333);
		exec(bse_pkg::op_compare_immediate, 0, 0, 1);
		rdchk(`BSE_OFF_FLAGS, 32'h02);
		// 0x80 - 0x01: signed overflow and half borrow, no carry
		apb(1'b1, `BSE_OFF_OPND, 32'h0180);
		exec(bse_pkg::op_compare_regs, 0, 0, 1);
		rdchk(`BSE_OFF_FLAGS, 32'h28);
		apb(1'b1, `BSE_OFF_FLAGS, 32'h01);
		apb(1'b1, `BSE_OFF_OPND, 32'h2021);
		exec(bse_pkg::op_compare_regs_carry, 0, 0, 1);
		rdchk(`BSE_OFF_FLAGS, 32'h00);
		apb(1'b1, `BSE_OFF_OPND, 32'h0077);
		exec(bse_pkg::op_reg_clear, 0, 0, 1);
		rdchk(`BSE_OFF_FLAGS, 32'h02);
		exec(bse_pkg::op_reg_set, 0, 0, 1);
		apb(1'b0, `BSE_OFF_STATE, 32'h0);
		check(rd[15:8], 8'hFF);
		$display("test compare done");
	endtask

	task t_skip;
		apb(1'b1, `BSE_OFF_PC, 32'h20);
		apb(1'b1, `BSE_OFF_NEXT, 32'h1);
		apb(1'b1, `BSE_OFF_OPND, 32'h5A5A);
		exec(bse_pkg::op_compare_skip_equal, 0, 0, 3);
		rdchk(`BSE_OFF_PC, 32'h23);
		apb(1'b1, `BSE_OFF_NEXT, 32'h0);
		apb(1'b1, `BSE_OFF_OPND, 32'h0001);
		exec(bse_pkg::op_compare_skip_equal, 0, 0, 1);
		exec(bse_pkg::op_skip_reg_bit_clear, 1, 0, 2);
		exec(bse_pkg::op_skip_reg_bit_clear, 0, 0, 1);
		exec(bse_pkg::op_skip_reg_bit_one, 1, 0, 1);
		exec(bse_pkg::op_skip_reg_bit_one, 0, 0, 2);
		apb(1'b1, 8'h2C, 32'h0F);
		exec(bse_pkg::op_io_bit_set_op, 7, 3, 2);
		rdchk(8'h2C, 32'h8F);
		exec(bse_pkg::op_io_bit_clear_op, 0, 3, 2);
		rdchk(8'h2C, 32'h8E);
		exec(bse_pkg::op_skip_io_bit_one, 7, 3, 2);
		exec(bse_pkg::op_skip_io_bit_one, 0, 3, 1);
		exec(bse_pkg::op_skip_io_bit_clear, 7, 3, 1);
		exec(bse_pkg::op_skip_io_bit_clear, 0, 3, 2);
		rdchk(`BSE_OFF_FLAGS, 32'h02);
		// unmapped read: error response and zero data
		apb(1'b0, 8'h40, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		$display("test skip and io done");
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_jumps();
		t_branch();
		t_cmp();
		t_skip();
		finish_test();
	end
endmodule // branch_skip_exec_control_bench
`default_nettype wire
